// ===== hw/uit_pkg.sv
// Purpose: shared constants and types of the usb toggle/irq/ep0 block
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes:   offsets are byte addresses

package uit_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_TX_TOGGLE    = 8'h00;
    localparam logic [7:0] OFS_TX_TOGGLE_EN = 8'h04;
    localparam logic [7:0] OFS_L1_STATUS    = 8'h08;
    localparam logic [7:0] OFS_L1_MASK      = 8'h0C;
    localparam logic [7:0] OFS_L1_POLARITY  = 8'h10;
    localparam logic [7:0] OFS_L1_CONTROL   = 8'h14;
    localparam logic [7:0] OFS_EP0_CSR      = 8'h18;

    // reset values
    localparam logic [11:0] RST_L1_MASK     = 12'h000;
    localparam logic [3:0]  RST_L1_POLARITY = 4'h2;
    localparam logic        RST_L1_CONTROL  = 1'b0;

    // level-1 source count, source, polarity and control bit positions
    localparam int L1_SRC_NUM      = 12;
    localparam int L1_LINE_ATTACH  = 7;
    localparam int L1_VBUS_OK      = 8;
    localparam int L1_POLAR_LSB    = 8;
    localparam int L1_CTRL_SYNC    = 0;

    // endpoint-0 control/status bit positions
    localparam int EP0_RX_READY    = 0;
    localparam int EP0_TX_READY    = 1;
    localparam int EP0_STALL_SENT  = 2;
    localparam int EP0_LAST_PKT    = 3;
    localparam int EP0_SETUP_ENDED = 4;
    localparam int EP0_STALL_REQ   = 5;
    localparam int EP0_RX_ACK      = 6;
    localparam int EP0_SETUP_ACK   = 7;
    localparam int EP0_FLUSH       = 8;

    // axi response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [1:0] LINE_SE0 = 2'h0;

    // phy/otg pins, all asynchronous to mclk
    typedef struct packed {
        logic       dp;
        logic       dm;
        logic [1:0] lineState;
        logic       vbusOk;
        logic       aSessionValid;
        logic       otgId;
    } uit_phy_type;

    // endpoint-0 handshake flags held by the device
    typedef struct packed {
        logic stallReq;
        logic setupEnded;
        logic lastPacket;
        logic stallSent;
        logic txReady;
        logic rxReady;
    } uit_ep0_type;

endpackage

// ===== hw/uit_usb_irq_toggle.sv
// Purpose: tx toggle write gating, level-1 irq combiner, ep0 handshake flags
// Assumes: axi4-lite master, phy pins asynchronous, event inputs on mclk
// Notes:   status register is live level, not sticky
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.

`timescale 1ns/1ps

// Functional notes
// - tx toggle write for endpoints 1-4 lands only while its enable bit is 1
// - power-down flag: host suspend+vbus+dp, peripheral+asession+dp, idle+no asession+se0
// - bit 10 shows vbus drive request against its polarity bit
// - bit 9 shows otg id input against its polarity bit
// - bit 8 shows vbus valid input against its polarity bit
// - bit 7 goes active when dp or dm is high
// - bits 6..0 show seven internal interrupt sources, read only
// - one mask bit per source, 1 passes it, all reset to 0
// - polarity bits 11..8, 1 triggers on low, only id polarity resets to 1
// - setup-end ack bit clears the setup-ended flag, self-clearing
module uit_usb_irq_toggle
    import uit_pkg::*;
#(
    parameter int ADDR_W    = 8,
    parameter int NUM_TX_EP = 4
)(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic [ADDR_W-1:0]    awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [ADDR_W-1:0]    araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready,
    input  wire uit_phy_type          phyPins,
    input  wire logic                 hostMode,
    input  wire logic                 hostSuspend,
    input  wire logic                 periMode,
    input  wire logic                 idleState,
    input  wire logic                 vbusDriveRequest,
    input  wire logic [6:0]           coreIrqSrc,
    input  wire logic [NUM_TX_EP-1:0] txToggleFlip,
    input  wire logic                 ep0RxArrived,
    input  wire logic                 ep0TxSent,
    input  wire logic                 ep0SetupEndEvt,
    input  wire logic                 ep0StallSentEvt,
    output logic                      usbIrq,
    output logic [NUM_TX_EP-1:0]      txToggleState,
    output logic                      ep0TxReady,
    output logic                      ep0StallRequest,
    output logic                      ep0LastPacket,
    output logic                      ep0FifoPtrReset
);

    // refuse shapes the fixed register layout cannot hold
    if (ADDR_W < 5 || NUM_TX_EP < 1 || NUM_TX_EP > 15)
    begin : g_bad_param
        $error("uit_usb_irq_toggle: unsupported ADDR_W or NUM_TX_EP");
    end

    logic [7:0]            awAddr_q;
    logic                  awHeld_q;
    logic [31:0]           wData_q;
    logic [3:0]            wStrb_q;
    logic                  wHeld_q;
    logic                  wrFire;
    logic [31:0]           wMask;
    logic                  wFull;
    logic [NUM_TX_EP-1:0]  toggleEn_q;
    logic [NUM_TX_EP-1:0]  toggle_q;
    logic [11:0]           mask_q;
    logic [3:0]            polar_q;
    logic                  ctrlSync_q;
    uit_ep0_type           ep0_q;
    logic                  flush_q;
    uit_phy_type           phyMeta_q;
    uit_phy_type           phy_q;
    logic [11:0]           status;
    logic                  irqComb;
    logic                  irq_q;

    // byte-lane enables expanded to bit mask
    function automatic logic [31:0] laneMask(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

    // address decode shared by both bus directions
    function automatic logic isMapped(input logic [7:0] a);
        return a == OFS_TX_TOGGLE || a == OFS_TX_TOGGLE_EN || a == OFS_L1_STATUS
            || a == OFS_L1_MASK || a == OFS_L1_POLARITY || a == OFS_L1_CONTROL
            || a == OFS_EP0_CSR;
    endfunction

    // two-stage synchroniser for the phy pins
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            phyMeta_q <= '0;
            phy_q     <= '0;
        end
        else
        begin
            phyMeta_q <= phyPins;
            phy_q     <= phyMeta_q;
        end
    end

    // write address channel, held until the data also arrives
    assign awready = !awHeld_q && !bvalid;
    assign wready  = !wHeld_q && !bvalid;
    assign wrFire  = awHeld_q && wHeld_q;
    assign wMask   = laneMask(wStrb_q);
    assign wFull   = wStrb_q == 4'hF;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            awHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
        end
        else if (awvalid && awready)
        begin
            awHeld_q <= 1'b1;
            awAddr_q <= 8'(awaddr);
        end
        else if (wrFire)
        begin
            awHeld_q <= 1'b0;
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
        end
        else if (wvalid && wready)
        begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end
        else if (wrFire)
        begin
            wHeld_q <= 1'b0;
        end
    end

    // write response one cycle after both halves are held
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end
        else if (wrFire)
        begin
            bvalid <= 1'b1;
            bresp  <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bready)
        begin
            bvalid <= 1'b0;
        end
    end

    // toggle enables; partial writes ignored to protect the gate
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            toggleEn_q <= '0;
        end
        else if (wrFire && awAddr_q == OFS_TX_TOGGLE_EN && wFull)
        begin
            toggleEn_q <= wData_q[NUM_TX_EP:1];
        end
    end

    // per-endpoint toggle: gated software write, else link flip
    for (genvar e = 0; e < NUM_TX_EP; e++)
    begin : g_toggle
        always_ff @(posedge mclk or posedge rst)
        begin
            if (rst)
            begin
                toggle_q[e] <= 1'b0;
            end
            else if (wrFire && awAddr_q == OFS_TX_TOGGLE && wMask[e+1] && toggleEn_q[e])
            begin
                toggle_q[e] <= wData_q[e+1];
            end
            else if (txToggleFlip[e])
            begin
                toggle_q[e] <= !toggle_q[e];
            end
        end
    end
    assign txToggleState = toggle_q;

    // mask, polarity and control registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mask_q     <= RST_L1_MASK;
            polar_q    <= RST_L1_POLARITY;
            ctrlSync_q <= RST_L1_CONTROL;
        end
        else if (wrFire)
        begin
            if (awAddr_q == OFS_L1_MASK)
            begin
                mask_q <= (mask_q & ~wMask[11:0]) | (wData_q[11:0] & wMask[11:0]);
            end
            if (awAddr_q == OFS_L1_POLARITY)
            begin
                polar_q <= (polar_q & ~wMask[11:8]) | (wData_q[11:8] & wMask[11:8]);
            end
            if (awAddr_q == OFS_L1_CONTROL && wMask[L1_CTRL_SYNC])
            begin
                ctrlSync_q <= wData_q[L1_CTRL_SYNC];
            end
        end
    end

    // live level-1 status; polarity 1 means trigger on low
    always_comb
    begin
        status[6:0]            = coreIrqSrc;
        status[L1_LINE_ATTACH] = phy_q.dp || phy_q.dm;
        status[8]  = phy_q.vbusOk ^ polar_q[0];
        status[9]  = phy_q.otgId ^ polar_q[1];
        status[10] = vbusDriveRequest ^ polar_q[2];
        status[11] = polar_q[3] ^ ((hostMode && hostSuspend && phy_q.vbusOk && phy_q.dp)
                   || (periMode && phy_q.aSessionValid && phy_q.dp)
                   || (idleState && !phy_q.aSessionValid && phy_q.lineState == LINE_SE0));
    end

    // combine unmasked sources into one line
    assign irqComb = |(status & mask_q);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irqComb;
        end
    end

    // registered path trades a cycle of latency for a glitch-free line
    assign usbIrq = ctrlSync_q ? irq_q : irqComb;

    // endpoint-0 flags; hardware set wins over software clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ep0_q <= '0;
        end
        else
        begin
            if (ep0RxArrived)
            begin
                ep0_q.rxReady <= 1'b1;
            end
            else if (wrFire && awAddr_q == OFS_EP0_CSR
                     && ((wMask[0] && wData_q[EP0_RX_ACK]) || (wMask[8] && wData_q[EP0_FLUSH])))
            begin
                ep0_q.rxReady <= 1'b0;
            end
            if (ep0TxSent || (wrFire && awAddr_q == OFS_EP0_CSR && wMask[8] && wData_q[EP0_FLUSH]))
            begin
                ep0_q.txReady    <= 1'b0;
                ep0_q.lastPacket <= 1'b0;
            end
            else if (wrFire && awAddr_q == OFS_EP0_CSR && wMask[0])
            begin
                ep0_q.txReady    <= ep0_q.txReady | wData_q[EP0_TX_READY];
                ep0_q.lastPacket <= ep0_q.lastPacket | wData_q[EP0_LAST_PKT];
            end
            if (ep0SetupEndEvt)
            begin
                ep0_q.setupEnded <= 1'b1;
            end
            else if (wrFire && awAddr_q == OFS_EP0_CSR && wMask[0] && wData_q[EP0_SETUP_ACK])
            begin
                ep0_q.setupEnded <= 1'b0;
            end
            if (ep0StallSentEvt)
            begin
                ep0_q.stallSent <= 1'b1;
                ep0_q.stallReq  <= 1'b0;
            end
            else if (wrFire && awAddr_q == OFS_EP0_CSR && wMask[0])
            begin
                ep0_q.stallSent <= ep0_q.stallSent & wData_q[EP0_STALL_SENT];
                ep0_q.stallReq  <= ep0_q.stallReq | wData_q[EP0_STALL_REQ];
            end
        end
    end

    // flush strobe lasts one cycle; the bit is not held in ep0_q, so it reads back as 0
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            flush_q <= 1'b0;
        end
        else
        begin
            flush_q <= wrFire && awAddr_q == OFS_EP0_CSR && wMask[8] && wData_q[EP0_FLUSH];
        end
    end

    assign ep0FifoPtrReset = flush_q;
    assign ep0TxReady      = ep0_q.txReady;
    assign ep0StallRequest = ep0_q.stallReq;
    assign ep0LastPacket   = ep0_q.lastPacket;

    // read channel, data registered one cycle after the address
    assign arready = !rvalid;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp  <= isMapped(8'(araddr)) ? RESP_OKAY : RESP_SLVERR;
            unique case (8'(araddr))
                OFS_TX_TOGGLE:    rdata <= 32'({toggle_q, 1'b0});
                OFS_TX_TOGGLE_EN: rdata <= 32'({toggleEn_q, 1'b0});
                OFS_L1_STATUS:    rdata <= 32'(status);
                OFS_L1_MASK:      rdata <= 32'(mask_q);
                OFS_L1_POLARITY:  rdata <= 32'({polar_q, 8'h00});
                OFS_L1_CONTROL:   rdata <= 32'(ctrlSync_q);
                OFS_EP0_CSR:      rdata <= 32'(ep0_q); // ack and flush bits read 0
                default:          rdata <= 32'h0000_0000;
            endcase
        end
        else if (rready)
        begin
            rvalid <= 1'b0;
        end
    end

endmodule

// ===== sim/uit_usb_irq_toggle_properties.sv
// Purpose: port-level assertions for the toggle/irq/ep0 block
// Assumes: one clock domain, rst async active high
// Notes:   bound to every instance of the design top

`timescale 1ns/1ps

module uit_usb_irq_toggle_properties
    import uit_pkg::*;
#(
    parameter int ADDR_W    = 8,
    parameter int NUM_TX_EP = 4
)(
    input wire logic                 mclk,
    input wire logic                 rst,
    input wire logic                 awvalid,
    input wire logic                 awready,
    input wire logic                 wvalid,
    input wire logic                 wready,
    input wire logic [1:0]           bresp,
    input wire logic                 bvalid,
    input wire logic                 bready,
    input wire logic                 arready,
    input wire logic                 arvalid,
    input wire logic [31:0]          rdata,
    input wire logic                 rvalid,
    input wire logic                 rready,
    input wire logic [NUM_TX_EP-1:0] txToggleFlip,
    input wire logic                 ep0TxSent,
    input wire logic                 ep0StallSentEvt,
    input wire logic                 usbIrq,
    input wire logic [NUM_TX_EP-1:0] txToggleState,
    input wire logic                 ep0TxReady,
    input wire logic                 ep0StallRequest,
    input wire logic                 ep0LastPacket,
    input wire logic                 ep0FifoPtrReset
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // a pending answer must not move until the master takes it
    sequence s_resp_wait; bvalid && !bready; endsequence
    sequence s_read_wait; rvalid && !rready; endsequence
    // bus idle: nothing held, nothing offered
    sequence s_bus_idle; awready && wready && !awvalid && !wvalid; endsequence

    property p_bresp_hold; s_resp_wait |=> bvalid && $stable(bresp); endproperty
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped early");
    property p_rdata_hold; s_read_wait |=> rvalid && $stable(rdata); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved while pending");
    property p_ar_block; arvalid && arready |=> rvalid && !arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read not answered next cycle");
    property p_aw_block; awvalid && awready && wvalid && wready |-> ##2 bvalid && !awready && !wready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write not answered in time");
    property p_flip; s_bus_idle ##0 txToggleFlip[0] |=> txToggleState[0] != $past(txToggleState[0]); endproperty
    a_flip: assert property (p_flip) else $error("toggle did not flip");
    property p_flush; ep0FifoPtrReset |-> !ep0TxReady && !ep0LastPacket ##1 !ep0FifoPtrReset; endproperty
    a_flush: assert property (p_flush) else $error("flush pulse wrong");
    property p_tx_sent; ep0TxSent |=> !ep0TxReady && !ep0LastPacket; endproperty
    a_tx_sent: assert property (p_tx_sent) else $error("tx ready kept after send");
    property p_stall_done; ep0StallSentEvt |=> !ep0StallRequest; endproperty
    a_stall_done: assert property (p_stall_done) else $error("stall request kept");
    property p_irq_rst; $fell(rst) |-> !usbIrq; endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq active with reset mask");
endmodule

bind uit_usb_irq_toggle uit_usb_irq_toggle_properties #(.ADDR_W(ADDR_W), .NUM_TX_EP(NUM_TX_EP)) u_props (
    .mclk(mclk), .rst(rst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .arready(arready), .rdata(rdata), .rvalid(rvalid),
    .rready(rready), .txToggleFlip(txToggleFlip), .ep0TxSent(ep0TxSent), .ep0StallSentEvt(ep0StallSentEvt),
    .usbIrq(usbIrq), .txToggleState(txToggleState), .ep0TxReady(ep0TxReady), .arvalid(arvalid),
    .ep0StallRequest(ep0StallRequest), .ep0LastPacket(ep0LastPacket), .ep0FifoPtrReset(ep0FifoPtrReset));

// ===== sim/uit_phy_partner.sv
// Purpose: far-side usb link model: phy pin levels and ep0 transmit
// Assumes: pin levels requested by the bench, lag in mclk cycles
// Notes:   hold stalls the link so software flags can be inspected

`timescale 1ns/1ps

module uit_phy_partner
    import uit_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [6:0] pinReq,
    input  wire logic       hold,
    input  wire logic [3:0] lag,
    input  wire logic       ep0TxReady,
    output uit_phy_type     phyPins,
    output logic            ep0TxSent
);
    logic [4:0] cnt_q;

    // pins are plain levels, the block syncs them itself
    assign phyPins = uit_phy_type'(pinReq);

    // send the packet once, lag cycles after ready is seen
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q     <= 5'h00;
            ep0TxSent <= 1'b0;
        end
        else
        begin
            ep0TxSent <= 1'b0;
            if (!ep0TxReady || hold)
                cnt_q <= 5'h00;
            else if (cnt_q == {1'b0, lag})
            begin
                ep0TxSent <= 1'b1;
                cnt_q     <= cnt_q + 5'h01;
            end
            else if (cnt_q < {1'b0, lag})
                cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule

// ===== sim/uit_usb_irq_toggle_tb_top.sv
// Purpose: self-checking bench for the toggle/irq/ep0 block
// Assumes: axi4-lite master tasks, expectations from a bench model
// Notes:   ready signals held back a cycle to exercise hold logic

`timescale 1ns/1ps

module uit_usb_irq_toggle_tb_top;
    import uit_pkg::*;

    logic        mclk = 1'b0, rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd, v, pol, msk, sts, tog;
    logic [3:0]  wstrb = 4'h0, txToggleFlip = 4'h0, lag = 4'h0, txToggleState;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        hostMode = 1'b0, hostSuspend = 1'b0, periMode = 1'b0, idleState = 1'b0, hold = 1'b1;
    logic        vbusDriveRequest = 1'b0, ep0RxArrived = 1'b0, ep0SetupEndEvt = 1'b0, ep0StallSentEvt = 1'b0;
    logic [6:0]  pinReq = 7'h00, coreIrqSrc = 7'h00;
    logic        awready, wready, bvalid, arready, rvalid, usbIrq, ep0TxSent;
    logic        ep0TxReady, ep0StallRequest, ep0LastPacket, ep0FifoPtrReset;
    logic [1:0]  bresp, rresp, rs;
    uit_phy_type phyPins;
    int          error_cnt = 0, compares = 0, seed = 76, flushCnt = 0, i, n;

    uit_usb_irq_toggle u_uit_usb_irq_toggle (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .phyPins(phyPins), .hostMode(hostMode),
        .hostSuspend(hostSuspend), .periMode(periMode), .idleState(idleState), .vbusDriveRequest(vbusDriveRequest),
        .coreIrqSrc(coreIrqSrc), .txToggleFlip(txToggleFlip), .ep0RxArrived(ep0RxArrived), .ep0TxSent(ep0TxSent),
        .ep0SetupEndEvt(ep0SetupEndEvt), .ep0StallSentEvt(ep0StallSentEvt), .usbIrq(usbIrq),
        .txToggleState(txToggleState), .ep0TxReady(ep0TxReady), .ep0StallRequest(ep0StallRequest),
        .ep0LastPacket(ep0LastPacket), .ep0FifoPtrReset(ep0FifoPtrReset));

    uit_phy_partner u_uit_phy_partner (.mclk(mclk), .rst(rst), .pinReq(pinReq), .hold(hold), .lag(lag),
        .ep0TxReady(ep0TxReady), .phyPins(phyPins), .ep0TxSent(ep0TxSent));

    // free-running clock
    always #25 mclk = ~mclk;

    // pulses are short, so count them in the background
    always @(posedge mclk)
        flushCnt += rst ? 0 : int'(ep0FifoPtrReset);

    task automatic tally_and_finish;
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic guard(input int k);
        if (k >= 40)
        begin
            error_cnt++;
            tally_and_finish;
        end
    endtask

    // write: both halves offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        int k;
        k = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (k >= 2) bready <= 1'b1;
            k++;
        end
        while (!(bvalid && bready) && k < 40);
        r = bresp;
        bready <= 1'b0;
        guard(k);
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        k = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (k >= 1) rready <= 1'b1;
            k++;
        end
        while (!(rvalid && rready) && k < 40);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        guard(k);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] r;
        axi_wr(a, d, s, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        check(d, exp);
    endtask

    // main sequence
    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rdchk(OFS_L1_MASK, 32'h0);
        rdchk(OFS_L1_POLARITY, 32'h200);
        rdchk(OFS_L1_CONTROL, 32'h0);
        rdchk(OFS_TX_TOGGLE_EN, 32'h0);
        rdchk(OFS_EP0_CSR, 32'h0);
        axi_wr(8'h1C, 32'hFFFFFFFF, 4'hF, rs);
        check({30'h0, rs}, {30'h0, RESP_SLVERR});
        axi_rd(8'h1C, rd, rs);
        check({30'h0, rs}, {30'h0, RESP_SLVERR});
        check(rd, 32'h0);
        // only the one enabled endpoint takes the write
        tog = 32'h0;
        for (i = 1; i <= 4; i++)
        begin
            wr(OFS_TX_TOGGLE, 32'h1E, 4'hF);
            rdchk(OFS_TX_TOGGLE, tog);
            wr(OFS_TX_TOGGLE_EN, 32'h1 << i, 4'hF);
            wr(OFS_TX_TOGGLE, 32'h1E, 4'hF);
            tog[i] = 1'b1;
            check({28'h0, txToggleState}, tog >> 1);
        end
        wr(OFS_TX_TOGGLE_EN, 32'h1E, 4'h3);
        rdchk(OFS_TX_TOGGLE_EN, 32'h10);
        wr(OFS_TX_TOGGLE_EN, 32'h1E, 4'hF);
        wr(OFS_TX_TOGGLE, 32'h0, 4'hF);
        txToggleFlip <= 4'h5;
        @(posedge mclk);
        txToggleFlip <= 4'h0;
        @(posedge mclk);
        check({28'h0, txToggleState}, 32'h5);
        // live status against polarity, mask and both output modes
        for (i = 0; i < 40; i++)
        begin
            v = $random(seed);
            pol = {20'h0, v[23:20], 8'h00};
            msk = $random(seed) & 32'hFFF;
            pinReq <= v[6:0];
            {hostMode, hostSuspend, periMode, idleState, vbusDriveRequest} <= v[11:7];
            coreIrqSrc <= v[18:12];
            wr(OFS_L1_POLARITY, pol, 4'hF);
            wr(OFS_L1_MASK, msk, 4'hF);
            wr(OFS_L1_CONTROL, {31'h0, v[24]}, 4'hF);
            sts = {20'h0, pol[11] ^ ((v[11] & v[10] & v[2] & v[6]) | (v[9] & v[1] & v[6])
                  | (v[8] & !v[1] & (v[4:3] == 2'h0))), v[7] ^ pol[10], v[0] ^ pol[9], v[2] ^ pol[8],
                  v[6] | v[5], v[18:12]};
            rdchk(OFS_L1_STATUS, sts);
            check({31'h0, usbIrq}, {31'h0, |(sts & msk)});
        end
        // endpoint-0 handshake flags, link stalled
        ep0RxArrived <= 1'b1;
        @(posedge mclk);
        ep0RxArrived <= 1'b0;
        rdchk(OFS_EP0_CSR, 32'h1);
        wr(OFS_EP0_CSR, 32'h40, 4'h1);
        rdchk(OFS_EP0_CSR, 32'h0);
        ep0SetupEndEvt <= 1'b1;
        @(posedge mclk);
        ep0SetupEndEvt <= 1'b0;
        rdchk(OFS_EP0_CSR, 32'h10);
        wr(OFS_EP0_CSR, 32'h80, 4'h1);
        rdchk(OFS_EP0_CSR, 32'h0);
        wr(OFS_EP0_CSR, 32'h20, 4'h1);
        check({31'h0, ep0StallRequest}, 32'h1);
        ep0StallSentEvt <= 1'b1;
        @(posedge mclk);
        ep0StallSentEvt <= 1'b0;
        rdchk(OFS_EP0_CSR, 32'h4);
        wr(OFS_EP0_CSR, 32'h0A, 4'h1);
        ep0RxArrived <= 1'b1;
        @(posedge mclk);
        ep0RxArrived <= 1'b0;
        rdchk(OFS_EP0_CSR, 32'h0B);
        check({30'h0, ep0TxReady, ep0LastPacket}, 32'h3);
        check({31'h0, ep0StallRequest}, 32'h0);
        wr(OFS_EP0_CSR, 32'h100, 4'h3);
        rdchk(OFS_EP0_CSR, 32'h0);
        check(flushCnt, 1);
        // link sends promptly, then slowly
        hold <= 1'b0;
        for (i = 0; i < 2; i++)
        begin
            lag <= i[0] ? 4'h6 : 4'h0;
            wr(OFS_EP0_CSR, 32'h0A, 4'h1);
            for (n = 0; n < 40 && ep0TxReady !== 1'b0; n++)
                @(posedge mclk);
            guard(n);
            rdchk(OFS_EP0_CSR, 32'h0);
        end
        tally_and_finish;
    end
endmodule
